// >>> rtl/irq_route_map.svh
// Purpose: constants for the master interrupt routing block
// Assumes: vector byte offset is four times the vector number
// Notes: line numbers are peripheral interrupt numbers, vector = line + 16
`ifndef IRQ_ROUTE_MAP_SVH
`define IRQ_ROUTE_MAP_SVH
`define NUM_LINES 92
`define LINE_BASE_VEC 16
`define VEC_RESET 7'h01
`define VEC_NMI 7'h02
`define VEC_HARD_FAULT 7'h03
`define LINE_WATCHDOG 7'h12
`define LINE_DMA_SW 7'h2e
`define LINE_DMA_ERR 7'h2f
`define LINE_CONV_FIRST 7'h48
`define LINE_RAM_SINGLE 7'h58
`define LINE_PLL_LOCK 7'h59
`define LINE_FLASH_SINGLE 7'h5a
// populated peripheral lines; a zero bit is a reserved line
`define LINE_VALID_MASK 92'h70fff0f1e60d43fd1fc01ff
// lines whose sources never go through the dma: i2c, watchdogs, can, converter
`define LINE_DIRECT_ONLY_MASK 92'h000ff0f0000002000040100
`define PRIO_RESET 8'h00
`endif

// >>> rtl/irq_route_pkg.sv
// Purpose: types for the master interrupt routing block
// Assumes: nothing beyond the map header
// Notes: level ordering, higher enum later wins among fixed levels
package irq_route_pkg;
    typedef enum logic [1:0] {
        lvl_none,
        lvl_hard_fault,
        lvl_nmi,
        lvl_reset
    } fixed_level_t;
    typedef enum logic [1:0] {
        st_idle,
        st_deliver
    } deliver_state_t;
endpackage

// >>> rtl/prio_table.sv
// Purpose: per-line programmable priority storage
// Assumes: one write port, every entry read at once on a flat output
// Notes: all entries clear to zero on reset
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_map.svh"
module prio_table #(
    parameter int DEPTH = 92,
    parameter int WIDTH = 8,
    parameter int AW = 7
) (
    // clocking
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // flat view for arbitration
    output logic [DEPTH*WIDTH-1:0] all_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    mem_q[g] <= WIDTH'(`PRIO_RESET);
                end else if (ce_in && wr_en_in && wr_addr_in == AW'(g)) begin
                    mem_q[g] <= wr_data_in;
                end
            end
            assign all_out[g*WIDTH +: WIDTH] = mem_q[g];
        end
    endgenerate
endmodule // prio_table
`default_nettype wire

// >>> rtl/master_interrupt_routing.sv
// Purpose: route and prioritise master-side interrupts to the core
// Assumes: all inputs synchronous to clk_in; sources are levels
// Notes: lower priority value wins; ties go to the lowest line
`timescale 1ns/1ps
`default_nettype none
`include "irq_route_map.svh"
module master_interrupt_routing #(
    parameter int NL = `NUM_LINES,
    parameter int PW = 8
) (
    // clocking
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // fixed sources
    input wire logic master_power_on_reset_req_in,
    input wire logic master_system_reset_req_in,
    input wire logic master_nonmaskable_req_in,
    // core faults and exceptions: [0] mem, [1] bus, [2] usage
    input wire logic [2:0] fault_req_in,
    input wire logic [2:0] fault_enabled_in,
    input wire logic [11:4] core_exc_req_in,
    // dma-capable peripheral requests and per-line channel enable
    input wire logic [NL-1:0] periph_req_in,
    input wire logic [NL-1:0] dma_chan_en_in,
    // dma controller events
    input wire logic dma_sw_done_in,
    input wire logic dma_error_in,
    // direct-only sources
    input wire logic [1:0] watchdog_irq_in,
    input wire logic [7:0] converter_irq_in,
    input wire logic sys_pll_unlock_in,
    input wire logic usb_pll_unlock_in,
    input wire logic ram_single_err_in,
    input wire logic flash_single_err_in,
    // priority programming
    input wire logic prio_wr_in,
    input wire logic [6:0] prio_addr_in,
    input wire logic [PW-1:0] prio_data_in,
    // to dma controller
    output logic [NL-1:0] dma_req_out,
    // to core
    output logic irq_valid_out,
    output logic [1:0] irq_level_out,
    output logic [6:0] irq_vector_out,
    output logic [9:0] irq_offset_out,
    output logic [NL-1:0] pending_out
);
    localparam logic [NL-1:0] VALID = NL'(`LINE_VALID_MASK);
    // watchdog, can, i2c and converter lines stay direct even with a channel enabled
    localparam logic [NL-1:0] DIRECT_ONLY = NL'(`LINE_DIRECT_ONLY_MASK);
    logic [NL*PW-1:0] prio_flat;
    prio_table #(.DEPTH(NL), .WIDTH(PW), .AW(7)) u_prio (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .wr_en_in(prio_wr_in),
        .wr_addr_in(prio_addr_in),
        .wr_data_in(prio_data_in),
        .all_out(prio_flat)
    );

    // direct lines; dma-routed peripherals go to the dma instead
    // a channel enable on a direct-only line is ignored rather than losing the request
    wire [NL-1:0] dma_sel = dma_chan_en_in & ~DIRECT_ONLY;
    wire [NL-1:0] dma_route = periph_req_in & dma_sel;
    wire [NL-1:0] direct_periph = periph_req_in & ~dma_sel;
    logic [NL-1:0] special;
    always_comb begin
        special = '0;
        special[`LINE_WATCHDOG] = |watchdog_irq_in;
        special[`LINE_DMA_SW] = dma_sw_done_in;
        special[`LINE_DMA_ERR] = dma_error_in;
        special[`LINE_CONV_FIRST +: 8] = converter_irq_in;
        special[`LINE_RAM_SINGLE] = ram_single_err_in;
        special[`LINE_PLL_LOCK] = sys_pll_unlock_in | usb_pll_unlock_in;
        special[`LINE_FLASH_SINGLE] = flash_single_err_in;
    end
    // nmi watchdog has no input here at all by design
    wire [NL-1:0] line_req = (direct_periph | special) & VALID;

    // exceptions 4..11 as one vector space with peripheral lines
    wire [2:0] fault_handled = fault_req_in & fault_enabled_in;
    wire hard_fault = |(fault_req_in & ~fault_enabled_in);

    // faults 4..6 come in handled form, the rest straight from the core
    wire [11:4] exc_req = {core_exc_req_in[11:7], fault_handled};

    // linear scan: strict less keeps lowest index on ties
    // exceptions carry priority zero here, so any of them beats every line;
    // a line can never be strictly below zero, which keeps that order fixed
    logic found;
    logic [PW-1:0] best_p;
    logic [6:0] best_v;
    always_comb begin
        found = 1'b0;
        best_p = '0;
        best_v = '0;
        for (int e = 4; e < 12; e++) begin
            if (exc_req[e] && !found) begin
                found = 1'b1;
                best_p = '0;
                best_v = 7'(e);
            end
        end
        for (int i = 0; i < NL; i++) begin
            if (line_req[i] && (!found || prio_flat[i*PW +: PW] < best_p)) begin
                found = 1'b1;
                best_p = prio_flat[i*PW +: PW];
                best_v = 7'(i + `LINE_BASE_VEC);
            end
        end
    end

    irq_route_pkg::fixed_level_t lvl;
    wire is_reset = master_power_on_reset_req_in | master_system_reset_req_in;
    assign lvl = is_reset ? irq_route_pkg::lvl_reset :
                 master_nonmaskable_req_in ? irq_route_pkg::lvl_nmi :
                 hard_fault ? irq_route_pkg::lvl_hard_fault :
                 irq_route_pkg::lvl_none;
    wire [6:0] win_vec = (lvl == irq_route_pkg::lvl_reset) ? `VEC_RESET :
                         (lvl == irq_route_pkg::lvl_nmi) ? `VEC_NMI :
                         (lvl == irq_route_pkg::lvl_hard_fault) ? `VEC_HARD_FAULT :
                         best_v;
    wire win_valid = (lvl != irq_route_pkg::lvl_none) | found;

    // core-facing word; a quiet cycle shows vector and offset zero
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_valid_out <= 1'b0;
            irq_level_out <= 2'h0;
            irq_vector_out <= 7'h00;
            irq_offset_out <= 10'h000;
        end else if (ce_in) begin
            irq_valid_out <= win_valid;
            irq_level_out <= lvl;
            irq_vector_out <= win_valid ? win_vec : 7'h00;
            irq_offset_out <= win_valid ? {1'b0, win_vec, 2'b00} : 10'h000;
        end
    end

    // pending shows direct lines only, after reserved masking
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pending_out <= '0;
        end else if (ce_in) begin
            pending_out <= line_req;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dma_req_out <= '0;
        end else if (ce_in) begin
            dma_req_out <= dma_route & VALID;
        end
    end

    a_reset_wins: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in && is_reset |=> irq_vector_out == `VEC_RESET && irq_level_out == 2'h3)
        else $error("reset not top priority");
    a_nmi_second: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in && !is_reset && master_nonmaskable_req_in |=> irq_vector_out == `VEC_NMI)
        else $error("nmi not second level");
    a_fault_escal: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in && !is_reset && !master_nonmaskable_req_in && |(fault_req_in & ~fault_enabled_in)
        |=> irq_vector_out == `VEC_HARD_FAULT)
        else $error("fault not escalated");
    a_reserved_quiet: assert property (@(posedge clk_in) disable iff (reset_in)
        (pending_out & ~VALID) == '0)
        else $error("reserved line pending");
    a_offset_vec: assert property (@(posedge clk_in) disable iff (reset_in)
        irq_valid_out |-> irq_offset_out == {1'b0, irq_vector_out, 2'b00})
        else $error("offset mismatch");
    a_prog_vec_range: assert property (@(posedge clk_in) disable iff (reset_in)
        irq_valid_out && irq_level_out == 2'h0 |-> irq_vector_out >= 7'h04
        && irq_vector_out <= 7'h6b)
        else $error("programmable vector out of range");
    a_wdog_line: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in && |watchdog_irq_in |=> pending_out[`LINE_WATCHDOG])
        else $error("watchdog line missing");
    a_pll_line: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in && (sys_pll_unlock_in || usb_pll_unlock_in) |=> pending_out[`LINE_PLL_LOCK])
        else $error("pll line missing");
    a_dma_done_line: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in && dma_sw_done_in |=> pending_out[`LINE_DMA_SW])
        else $error("dma completion line missing");
    a_dma_split: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in |=> (dma_req_out & pending_out & ~$past(special)) == '0)
        else $error("line both dma and direct");
    a_direct_bypass: assert property (@(posedge clk_in) disable iff (reset_in)
        (dma_req_out & DIRECT_ONLY) == '0)
        else $error("direct-only line forwarded to dma");
    a_conv_map: assert property (@(posedge clk_in) disable iff (reset_in)
        ce_in |=> pending_out[`LINE_CONV_FIRST +: 8] == $past(converter_irq_in))
        else $error("converter lines wrong");
    // a frozen cycle must leave the vector, pending and dma request outputs where they were
    a_ce_freeze: assert property (@(posedge clk_in) disable iff (reset_in)
        !ce_in |=> $stable(irq_vector_out) && $stable(pending_out) && $stable(dma_req_out))
        else $error("outputs moved while clock enable low");

    // main delivery cases
    c_reset: cover property (@(posedge clk_in) irq_level_out == 2'h3);
    c_nmi: cover property (@(posedge clk_in) irq_level_out == 2'h2);
    c_hard: cover property (@(posedge clk_in) irq_vector_out == `VEC_HARD_FAULT);
    c_periph: cover property (@(posedge clk_in) irq_valid_out && irq_vector_out >= 7'h10);
    c_dma_done: cover property (@(posedge clk_in) pending_out[`LINE_DMA_SW]);
endmodule // master_interrupt_routing
`default_nettype wire

// >>> test/dma_core_model.sv
// Purpose: far side of the routing block, the dma engine answering forwarded requests
// Assumes: requests are levels; completion is reported as a level on the software done line
// Notes: DELAY sets how slowly the engine answers; done drops as soon as requests go away
`timescale 1ns/1ps
`default_nettype none
module dma_core_model #(
    parameter int DELAY = 3
) (
    // clocking
    input wire logic clk_in,
    input wire logic reset_in,
    // from the routing block
    input wire logic [91:0] dma_req_in,
    // back to the routing block
    output logic sw_done_out
);
    int cnt;
    initial sw_done_out = 1'b0;
    // driven on the falling edge, like the rest of the stimulus
    always @(negedge clk_in) begin
        if (reset_in || dma_req_in == '0) begin
            cnt <= 0;
            sw_done_out <= 1'b0;
        end else if (cnt == DELAY) begin
            sw_done_out <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // dma_core_model
`default_nettype wire

// >>> test/master_interrupt_routing_bench.sv
// Purpose: self-checking bench for the master interrupt routing block
// Assumes: outputs follow inputs one clock later; inputs change on the falling edge
// Notes: table rows raise one source each; mixed and ordering cases follow by hand
`timescale 1ns/1ps
`default_nettype none
module master_interrupt_routing_bench;
    `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
        $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
    typedef struct {logic [3:0] k; logic [6:0] i; logic [1:0] l; logic [6:0] v;} row_t;
    logic clk_in, reset_in, ce_in, por, srst, nmi, sw_done, dma_err, spll, upll, ram, flash;
    logic pwr, valid;
    logic [2:0] freq, fen;
    logic [11:4] exc;
    logic [91:0] preq, dmaen, dreq, pend;
    logic [1:0] wd, lvl;
    logic [7:0] conv, pdata;
    logic [6:0] paddr, vec;
    logic [9:0] off;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    row_t rows[19] = '{'{0, 0, 0, 16}, '{0, 60, 0, 76}, '{1, 0, 0, 88}, '{1, 7, 0, 95},
        '{2, 0, 0, 34}, '{2, 1, 0, 34}, '{3, 0, 0, 105}, '{3, 1, 0, 105}, '{4, 0, 0, 63},
        '{5, 0, 0, 104}, '{5, 1, 0, 106}, '{6, 0, 2, 2}, '{7, 0, 3, 1}, '{7, 1, 3, 1},
        '{8, 0, 1, 3}, '{8, 2, 1, 3}, '{9, 0, 0, 4}, '{9, 1, 0, 5}, '{10, 11, 0, 11}};
    master_interrupt_routing i_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
        .master_power_on_reset_req_in(por), .master_system_reset_req_in(srst),
        .master_nonmaskable_req_in(nmi), .fault_req_in(freq), .fault_enabled_in(fen),
        .core_exc_req_in(exc), .periph_req_in(preq), .dma_chan_en_in(dmaen),
        .dma_sw_done_in(sw_done), .dma_error_in(dma_err), .watchdog_irq_in(wd),
        .converter_irq_in(conv), .sys_pll_unlock_in(spll), .usb_pll_unlock_in(upll),
        .ram_single_err_in(ram), .flash_single_err_in(flash), .prio_wr_in(pwr),
        .prio_addr_in(paddr), .prio_data_in(pdata), .dma_req_out(dreq),
        .irq_valid_out(valid), .irq_level_out(lvl), .irq_vector_out(vec),
        .irq_offset_out(off), .pending_out(pend));
    dma_core_model #(.DELAY(3)) i_far (.clk_in(clk_in), .reset_in(reset_in),
        .dma_req_in(dreq), .sw_done_out(sw_done));
    task automatic clear();
        {por, srst, nmi, dma_err, spll, upll, ram, flash, pwr} = '0;
        {freq, fen, exc, wd, conv, paddr, pdata} = '0;
        preq = '0;
        dmaen = '0;
    endtask
    task automatic drive(input logic [3:0] k, input logic [6:0] i);
        case (k)
            0: preq[i] = 1'b1;
            1: conv[i[2:0]] = 1'b1;
            2: wd[i[0]] = 1'b1;
            3: if (i[0]) upll = 1'b1; else spll = 1'b1;
            4: dma_err = 1'b1;
            5: if (i[0]) flash = 1'b1; else ram = 1'b1;
            6: nmi = 1'b1;
            7: if (i[0]) srst = 1'b1; else por = 1'b1;
            8: freq[i[1:0]] = 1'b1;
            9: {freq[i[1:0]], fen[i[1:0]]} = 2'b11;
            default: exc[i[3:0]] = 1'b1;
        endcase
    endtask
    // one rising edge passes, outputs are looked at settled on the falling edge
    task automatic step();
        @(negedge clk_in);
    endtask
    task automatic look(input logic [1:0] l, input logic [6:0] v);
        `CHK(valid, 1'b1)
        `CHK(lvl, l)
        `CHK(vec, v)
        `CHK(off, {1'b0, v, 2'b00})
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // hang guard: the whole sequence needs well under a hundred cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        reset_in = 1'b1;
        ce_in = 1'b1;
        clear();
        repeat (6) step();
        `CHK(valid, 1'b0)
        `CHK(pend, 92'h0)
        reset_in = 1'b0;
        foreach (rows[n]) begin
            clear();
            drive(rows[n].k, rows[n].i);
            step();
            look(rows[n].l, rows[n].v);
        end
        clear();
        preq[9] = 1'b1;
        preq[91] = 1'b1;
        dmaen[9] = 1'b1;
        step();
        `CHK({valid, pend, dreq}, 185'h0)
        clear();
        {por, nmi, freq[1], conv[0]} = 4'hf;
        step();
        look(3, 1);
        por = 1'b0;
        step();
        look(2, 2);
        nmi = 1'b0;
        step();
        look(1, 3);
        clear();
        preq[3] = 1'b1;
        conv[0] = 1'b1;
        step();
        look(0, 19);
        {pwr, paddr, pdata} = {1'b1, 7'h03, 8'h05};
        step();
        pwr = 1'b0;
        step();
        look(0, 88);
        `CHK({pend[3], pend[72]}, 2'b11)
        // reset in mid-run with sources still raised: outputs clear, priorities back to zero
        reset_in = 1'b1;
        step();
        `CHK({valid, lvl, vec, pend}, 102'h0)
        reset_in = 1'b0;
        step();
        look(0, 19);
        // clock enable low freezes the delivered word while the inputs drop
        ce_in = 1'b0;
        clear();
        step();
        `CHK({valid, vec, pend[3], pend[72]}, {1'b1, 7'h13, 2'b11})
        ce_in = 1'b1;
        clear();
        dmaen = '1;
        {preq[0], preq[8], conv[0], wd[0]} = 4'hf;
        step();
        `CHK({dreq[0], pend[0]}, 2'b10)
        `CHK({dreq[72], dreq[18], dreq[8], pend[72], pend[18], pend[8]}, 6'b000111)
        // drop the direct sources so completion can win; done shows DELAY+1 looks later
        {preq[8], conv[0], wd[0]} = 3'b000;
        repeat (4) step();
        look(0, 62);
        finish_test();
    end
endmodule // master_interrupt_routing_bench
`default_nettype wire
